// ==== rtl/srf_fifo.sv ====
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Shift-style queue: the head entry is always slot 0, so read data come straight out of a flop

module srf_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic             inValid,
  output      logic             inReady,
  input  wire logic [WIDTH-1:0] inData,
  output      logic             outValid,
  input  wire logic             outReady,
  output      logic [WIDTH-1:0] outData
);

  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] slot [DEPTH];
  logic [CW-1:0]    count;
  logic             push;
  logic             pop;
  logic [CW-1:0]    next_count;

  generate
    if (DEPTH < 2)
    begin : g_bad_depth
      $error("srf_fifo needs DEPTH of at least 2");
    end
  endgenerate

  assign inReady    = (count != CW'(DEPTH));
  assign outValid   = (count != '0);
  assign push       = inValid & inReady;
  assign pop        = outValid & outReady;
  assign outData    = slot[0];
  assign next_count = CW'(count + CW'(push) - CW'(pop));

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      count <= '0;
    else
      count <= next_count;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Each slot takes its upper neighbour on a pop (the top slot takes zero), or the new word when it is the write target

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++)
    begin : g_slot
      logic [WIDTH-1:0] above;
      logic             takeNew;
      assign above   = (i == DEPTH - 1) ? '0 : slot[(i == DEPTH - 1) ? i : i + 1];
      assign takeNew = push && (CW'(i) == (pop ? CW'(count - CW'(1)) : count));
      always_ff @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
          slot[i] <= '0;
        else if (takeNew)
          slot[i] <= inData;
        else if (pop)
          slot[i] <= above;
      end
    end
  endgenerate

endmodule : srf_fifo

// ==== rtl/srf_serial_ready.sv ====
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Shared constants

package srf_pkg;

  localparam int          CMD_W      = 8;
  localparam int          ADDR_W     = 3;
  localparam int          DATA_W     = 24;
  localparam int          WORD_W     = ADDR_W + DATA_W;
  localparam int          CMD_RD_BIT = 7;
  localparam int          CNT_W      = 6;
  localparam int          FIFO_DEPTH = 8;

  localparam logic [5:0]  CMD_LAST   = 6'h07;
  localparam logic [5:0]  GAP_LAST   = 6'h0F;
  localparam logic [5:0]  RD_LOAD    = 6'h10;
  localparam logic [5:0]  WR_LAST    = 6'h1F;
  localparam logic [5:0]  RD_LAST    = 6'h27;

  localparam logic [2:0]  REG_STATUS = 3'h0;
  localparam logic [2:0]  REG_MODE   = 3'h1;
  localparam logic [2:0]  REG_MAIN   = 3'h2;
  localparam logic [2:0]  REG_AUX    = 3'h3;
  localparam logic [2:0]  REG_CONFIG = 3'h4;
  localparam logic [2:0]  REG_CALIB  = 3'h5;

  localparam int          ST_MAIN    = 0;
  localparam int          ST_AUX     = 1;
  localparam int          ST_CAL     = 2;

  localparam logic [7:0]  MODE_RESET   = 8'h00;
  localparam logic [23:0] CONFIG_RESET = 24'h000000;
  localparam logic [23:0] CALIB_RESET  = 24'h000000;

  typedef enum logic [2:0] {
    PH_CMD  = 3'b001,
    PH_GAP  = 3'b010,
    PH_DATA = 3'b100
  } srf_phase_t;

endpackage : srf_pkg

////////////////////////////////////////////////////////////////////////////////

// What this block does
// R1 - Active-low select; device acts only when selected
// R2 - Select edges delimit each serial frame
// R3 - Select tied low still works, frames self-delimit
// R4 - Ready low when either channel has result
// R5 - Ready is NOR of channel result flags
// R6 - Ready returns high after data read completes
// R7 - Unread result clears just before next update
// R8 - Host avoids reads while ready high pre-update
// R9 - Ready goes low when calibration finishes
// R10 - Calibration ready holds until mode write
// R11 - Disabled channel is masked out of ready
// R12 - Host reads disabled channel data to release
// R13 - Output shifter loads any readable register
// R14 - Input shifter written to selected register
// R15 - Serial clock may be continuous or bursty
// R16 - Reset returns everything to power-on state
// R17 - Deselected: clock ignored, output undriven
module srf_serial_ready #(
  parameter int MAIN_W = 24,
  parameter int AUX_W  = 16
) (
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic              sclk,
  input  wire logic              csN,
  input  wire logic              din,
  output      logic              dout,
  output      logic              doutEn,
  output      logic              readyN,
  input  wire logic [MAIN_W-1:0] mainResult,
  input  wire logic              mainStrobe,
  input  wire logic              mainUpdateSoon,
  input  wire logic              mainEnable,
  input  wire logic [AUX_W-1:0]  auxResult,
  input  wire logic              auxStrobe,
  input  wire logic              auxUpdateSoon,
  input  wire logic              auxEnable,
  input  wire logic              calDone,
  input  wire logic              applyHold,
  input  wire logic              lostClear,
  output      logic [7:0]        modeBits,
  output      logic              modeWritten,
  output      logic [23:0]       configReg,
  output      logic [23:0]       calibReg,
  output      logic              cmdFifoReady,
  output      logic              writeLost,
  output      logic [2:0]        statusFlags
);

  generate
    if (MAIN_W > srf_pkg::DATA_W || AUX_W > MAIN_W || AUX_W < 1)
    begin : g_bad_width
      $error("srf_serial_ready needs 1 <= AUX_W <= MAIN_W <= 24");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Link side, clocked by sclk

  logic                            linkClr;
  srf_pkg::srf_phase_t             phase;
  srf_pkg::srf_phase_t             next_phase;
  logic [srf_pkg::CNT_W-1:0]       bitCnt;
  logic [srf_pkg::CNT_W-1:0]       next_bitCnt;
  logic [srf_pkg::DATA_W-1:0]      inSr;
  logic [srf_pkg::CMD_W-1:0]       nextCmd;
  logic [srf_pkg::DATA_W-1:0]      nextData;
  logic [srf_pkg::CMD_W-1:0]       cmdHeld;
  logic [srf_pkg::WORD_W-1:0]      wrWord;
  logic                            cmdEnd;
  logic                            gapEnd;
  logic                            frameEnd;
  logic                            wrEnd;
  logic                            rdEnd;
  logic                            heldRead;
  logic                            reqTog;
  logic                            wrTog;
  logic                            rdTog;
  logic                            ackMeta;
  logic                            ackSync;
  logic                            ackTog;
  logic [srf_pkg::DATA_W-1:0]      readWord;
  logic [srf_pkg::DATA_W-1:0]      doutSr;
  logic                            doutLoad;
  logic                            doutShift;

  // Deselect or reset clears the frame position; the toggles survive a deselect so no false event appears
  assign linkClr  = ~rstn | csN;                                          // see R1 see R2 see R16
  assign nextCmd  = {inSr[srf_pkg::CMD_W-2:0], din};
  assign nextData = {inSr[srf_pkg::DATA_W-2:0], din};
  assign heldRead = cmdHeld[srf_pkg::CMD_RD_BIT];
  assign cmdEnd   = (phase == srf_pkg::PH_CMD) && (bitCnt == srf_pkg::CMD_LAST);
  assign gapEnd   = (phase == srf_pkg::PH_GAP) && (bitCnt == srf_pkg::GAP_LAST);
  assign frameEnd = (phase == srf_pkg::PH_DATA)
                  && (bitCnt == (heldRead ? srf_pkg::RD_LAST : srf_pkg::WR_LAST));
  assign wrEnd    = frameEnd & ~heldRead;
  assign rdEnd    = frameEnd & heldRead;

  // Frame length alone ends a frame, so a select held low keeps working
  assign next_bitCnt = frameEnd ? '0 : srf_pkg::CNT_W'(bitCnt + 6'h01);   // see R3

  always_comb
  begin
    next_phase = phase;
    case (phase)
      srf_pkg::PH_CMD:
        if (cmdEnd)
          next_phase = nextCmd[srf_pkg::CMD_RD_BIT] ? srf_pkg::PH_GAP : srf_pkg::PH_DATA;
      srf_pkg::PH_GAP:
        if (gapEnd)
          next_phase = srf_pkg::PH_DATA;
      srf_pkg::PH_DATA:
        if (frameEnd)
          next_phase = srf_pkg::PH_CMD;                                   // see R3
      default:
        next_phase = srf_pkg::PH_CMD;
    endcase
  end

  // Only edges count, never time between them, so bursty clocks are fine
  always_ff @(posedge sclk or posedge linkClr)
  begin
    if (linkClr)
    begin
      phase  <= srf_pkg::PH_CMD;
      bitCnt <= '0;
      inSr   <= '0;
    end
    else
    begin
      phase  <= next_phase;                                               // see R15
      bitCnt <= next_bitCnt;
      inSr   <= nextData;
    end
  end

  // Held words stay put until the next frame, long after the core has taken them
  always_ff @(posedge sclk or negedge rstn)
  begin
    if (!rstn)
    begin
      cmdHeld <= '0;
      wrWord  <= '0;
      reqTog  <= 1'b0;
      wrTog   <= 1'b0;
      rdTog   <= 1'b0;
    end
    else
    begin
      if (cmdEnd && !csN)
        cmdHeld <= nextCmd;
      if (cmdEnd && !csN && nextCmd[srf_pkg::CMD_RD_BIT])
        reqTog <= ~reqTog;
      if (wrEnd && !csN)
      begin
        wrWord <= {cmdHeld[srf_pkg::ADDR_W-1:0], nextData};               // see R14
        wrTog  <= ~wrTog;
      end
      if (rdEnd && !csN)
        rdTog <= ~rdTog;                                                  // see R6
    end
  end

  always_ff @(posedge sclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ackMeta <= 1'b0;
      ackSync <= 1'b0;
    end
    else
    begin
      ackMeta <= ackTog;
      ackSync <= ackMeta;
    end
  end

  // Eight gap clocks give the core time to answer; a late answer shifts out zeros
  assign doutLoad  = heldRead && (phase == srf_pkg::PH_DATA) && (bitCnt == srf_pkg::RD_LOAD);
  assign doutShift = heldRead && (phase == srf_pkg::PH_DATA);

  always_ff @(negedge sclk or posedge linkClr)
  begin
    if (linkClr)
      doutSr <= '0;
    else if (doutLoad)
      doutSr <= (ackSync == reqTog) ? readWord : '0;                      // see R13
    else if (doutShift)
      doutSr <= {doutSr[srf_pkg::DATA_W-2:0], 1'b0};
  end

  assign dout   = doutSr[srf_pkg::DATA_W-1];
  assign doutEn = rstn & ~csN;                                            // see R17

  ////////////////////////////////////////////////////////////////////////////////
  // Event crossings into sys_clk: two flops, then a third for the edge

  logic [2:0] linkTog;
  logic [2:0] togMeta;
  logic [2:0] togSync;
  logic [2:0] togLast;
  logic [2:0] linkEvt;
  logic       reqEvt;
  logic       wrEvt;
  logic       rdEvt;

  assign linkTog = {rdTog, wrTog, reqTog};

  genvar e;
  generate
    for (e = 0; e < 3; e++)
    begin : g_evt_sync
      always_ff @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          togMeta[e] <= 1'b0;
          togSync[e] <= 1'b0;
          togLast[e] <= 1'b0;
        end
        else
        begin
          togMeta[e] <= linkTog[e];
          togSync[e] <= togMeta[e];
          togLast[e] <= togSync[e];
        end
      end
      assign linkEvt[e] = togSync[e] ^ togLast[e];
    end
  endgenerate

  assign reqEvt = linkEvt[0];
  assign wrEvt  = linkEvt[1];
  assign rdEvt  = linkEvt[2];

  ////////////////////////////////////////////////////////////////////////////////
  // Writes queue up so the converter side may stall applying them

  logic [srf_pkg::WORD_W-1:0] fifoOut;
  logic                       fifoOutValid;
  logic                       applyEn;
  logic [srf_pkg::ADDR_W-1:0] wrAddr;
  logic [srf_pkg::DATA_W-1:0] wrData;
  logic                       modeWr;
  logic                       configWr;
  logic                       calibWr;

  srf_fifo #(
    .WIDTH (srf_pkg::WORD_W),
    .DEPTH (srf_pkg::FIFO_DEPTH)
  ) u_cmd_fifo (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .inValid  (wrEvt),
    .inReady  (cmdFifoReady),
    .inData   (wrWord),
    .outValid (fifoOutValid),
    .outReady (~applyHold),
    .outData  (fifoOut)
  );

  assign applyEn  = fifoOutValid & ~applyHold;
  assign wrAddr   = fifoOut[srf_pkg::WORD_W-1:srf_pkg::DATA_W];
  assign wrData   = fifoOut[srf_pkg::DATA_W-1:0];
  assign modeWr   = applyEn && (wrAddr == srf_pkg::REG_MODE);
  assign configWr = applyEn && (wrAddr == srf_pkg::REG_CONFIG);
  assign calibWr  = applyEn && (wrAddr == srf_pkg::REG_CALIB);

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      modeBits    <= srf_pkg::MODE_RESET;
      configReg   <= srf_pkg::CONFIG_RESET;
      calibReg    <= srf_pkg::CALIB_RESET;
      modeWritten <= 1'b0;
    end
    else
    begin
      modeWritten <= modeWr;
      if (modeWr)
        modeBits <= wrData[7:0];                                          // see R14
      if (configWr)
        configReg <= wrData;                                              // see R14
      if (calibWr)
        calibReg <= wrData;                                               // see R14
    end
  end

  // A full queue cannot push back on the host, so the loss is only reported
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      writeLost <= 1'b0;
    else
      writeLost <= (wrEvt & ~cmdFifoReady) | (writeLost & ~lostClear);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Result flags and the ready output

  logic [MAIN_W-1:0] mainData;
  logic [AUX_W-1:0]  auxData;
  logic              mainFlag;
  logic              auxFlag;
  logic              calFlag;
  logic              rdAddrMain;
  logic              rdAddrAux;
  logic              next_mainFlag;
  logic              next_auxFlag;
  logic              next_calFlag;
  logic              anyReady;

  assign rdAddrMain = rdEvt && (cmdHeld[srf_pkg::ADDR_W-1:0] == srf_pkg::REG_MAIN);
  assign rdAddrAux  = rdEvt && (cmdHeld[srf_pkg::ADDR_W-1:0] == srf_pkg::REG_AUX);

  // A new result in the same cycle as a clear keeps its flag
  assign next_mainFlag = mainStrobe | (mainFlag & ~rdAddrMain & ~mainUpdateSoon);  // see R4 see R6 see R7
  assign next_auxFlag  = auxStrobe | (auxFlag & ~rdAddrAux & ~auxUpdateSoon);      // see R4 see R6 see R7
  assign next_calFlag  = calDone | (calFlag & ~modeWr);                            // see R9 see R10

  assign anyReady = (mainFlag & mainEnable) | (auxFlag & auxEnable) | calFlag;     // see R5 see R11

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mainFlag <= 1'b0;
      auxFlag  <= 1'b0;
      calFlag  <= 1'b0;
      mainData <= '0;
      auxData  <= '0;
      readyN   <= 1'b1;
    end
    else
    begin
      mainFlag <= next_mainFlag;
      auxFlag  <= next_auxFlag;
      calFlag  <= next_calFlag;
      if (mainStrobe)
        mainData <= mainResult;
      if (auxStrobe)
        auxData <= auxResult;
      readyN <= ~anyReady;                                                // see R5
    end
  end

  assign statusFlags = {calFlag, auxFlag, mainFlag};

  ////////////////////////////////////////////////////////////////////////////////
  // Read answers: the word is held still and acknowledged by a toggle

  logic [srf_pkg::ADDR_W-1:0] reqAddr;
  logic [srf_pkg::DATA_W-1:0] statusWord;
  logic [srf_pkg::DATA_W-1:0] readMux;

  assign reqAddr    = cmdHeld[srf_pkg::ADDR_W-1:0];
  assign statusWord = {{(srf_pkg::DATA_W - 3){1'b0}}, statusFlags};

  assign readMux = (reqAddr == srf_pkg::REG_STATUS) ? statusWord
                 : (reqAddr == srf_pkg::REG_MODE)   ? {16'h0000, modeBits}
                 : (reqAddr == srf_pkg::REG_MAIN)   ? srf_pkg::DATA_W'(mainData)
                 : (reqAddr == srf_pkg::REG_AUX)    ? srf_pkg::DATA_W'(auxData)
                 : (reqAddr == srf_pkg::REG_CONFIG) ? configReg
                 : (reqAddr == srf_pkg::REG_CALIB)  ? calibReg
                 : '0;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      readWord <= '0;
      ackTog   <= 1'b0;
    end
    else if (reqEvt)
    begin
      readWord <= readMux;                                                // see R13
      ackTog   <= ~ackTog;
    end
  end

endmodule : srf_serial_ready

// ==== verif/srf_serial_ready_monitor.sv ====
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Port-level checks on the core clock

module srf_serial_ready_monitor (
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic       csN,
  input wire logic       doutEn,
  input wire logic       readyN,
  input wire logic       mainStrobe,
  input wire logic       mainUpdateSoon,
  input wire logic       mainEnable,
  input wire logic       auxStrobe,
  input wire logic       auxUpdateSoon,
  input wire logic       auxEnable,
  input wire logic       calDone,
  input wire logic [7:0] modeBits,
  input wire logic       modeWritten,
  input wire logic [2:0] statusFlags
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  // Masked flags; a disabled channel keeps its flag but must not pull ready
  wire anyFlag = (statusFlags[0] & mainEnable) | (statusFlags[1] & auxEnable) | statusFlags[2];

  sequence s_main_new;
    mainStrobe && mainEnable ##1 mainEnable;
  endsequence

  a_ready_nor: assert property (1'b1 |=> readyN == !$past(anyFlag))
    else $error("readyN is not the NOR of the enabled flags");
  a_main_ready: assert property (s_main_new |=> !readyN)
    else $error("readyN not low two cycles after a main result");
  a_aux_set: assert property (auxStrobe |=> statusFlags[1])
    else $error("aux flag not set by a new result");
  a_cal_set: assert property (calDone |=> statusFlags[2])
    else $error("cal flag not set at calibration end");
  a_cal_hold: assert property ($fell(statusFlags[2]) |-> ##[0:2] modeWritten)
    else $error("cal flag cleared without a mode write");
  a_update_clear: assert property (mainUpdateSoon && !mainStrobe |=> !statusFlags[0])
    else $error("main flag kept across an update warning");
  a_aux_clear: assert property (auxUpdateSoon && !auxStrobe |=> !statusFlags[1])
    else $error("aux flag kept across an update warning");
  a_mode_pulse: assert property ($changed(modeBits) |-> ##[0:2] modeWritten)
    else $error("mode changed without its write pulse");
  a_deselect_off: assert property (csN |-> !doutEn)
    else $error("dout driven while deselected");
  a_select_on: assert property (!csN |-> doutEn)
    else $error("dout not driven while selected");
endmodule : srf_serial_ready_monitor

bind srf_serial_ready srf_serial_ready_monitor u_mon (
  .sys_clk(sys_clk), .rstn(rstn), .csN(csN), .doutEn(doutEn), .readyN(readyN),
  .mainStrobe(mainStrobe), .mainUpdateSoon(mainUpdateSoon), .mainEnable(mainEnable),
  .auxStrobe(auxStrobe), .auxUpdateSoon(auxUpdateSoon), .auxEnable(auxEnable), .calDone(calDone),
  .modeBits(modeBits),
  .modeWritten(modeWritten), .statusFlags(statusFlags)
);

// ==== verif/srf_host_model.sv ====
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Serial host: clock idles high and runs only inside frames, 80 ns period

module srf_host_model (
  output logic      sclk,
  output logic      csN,
  output logic      din,
  input  wire logic dout,
  input  wire logic doutEn
);
  logic [23:0] lastWord;
  event        gotWord;

  initial
  begin
    sclk     = 1'b1;
    csN      = 1'b1;
    din      = 1'b1;
    lastWord = 24'h000000;
  end

  // Odd start offset keeps link edges off the core clock edges
  task automatic frame(input logic [7:0] cmd, input logic [23:0] wd, input logic hold, input logic pause);
    int          n;
    logic [23:0] rd;
    n  = cmd[7] ? 40 : 32;
    rd = 24'h000000;
    #2.7;
    csN = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      #40;
      sclk = 1'b0;
      din  = (i < 8) ? cmd[7-i] : (cmd[7] ? ~din : wd[(31-i) & 31]);
      #40;
      sclk = 1'b1;
      if (i >= 16)
        rd = {rd[22:0], doutEn ? dout : ~dout};
      if (pause && i == 7)
        #400;
    end
    #40;
    if (!hold)
      csN = 1'b1;
    din = ~din;
    if (cmd[7])
    begin
      lastWord = rd;
      -> gotWord;
    end
  endtask : frame
endmodule : srf_host_model

// ==== verif/srf_serial_ready_tb.sv ====
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////

module srf_serial_ready_tb;
  logic        sys_clk, rstn, mainStrobe, mainUpdateSoon, mainEnable, auxStrobe, auxUpdateSoon;
  logic        auxEnable, calDone, applyHold, lostClear;
  logic [23:0] mainResult, v;
  logic [15:0] auxResult;
  logic [7:0]  m;
  wire         sclk, csN, din, dout, doutEn, readyN, modeWritten, cmdFifoReady, writeLost;
  wire  [7:0]  modeBits;
  wire  [23:0] configReg, calibReg;
  wire  [2:0]  statusFlags;
  int          error_cnt, checked, cycles, seed;
  logic [23:0] readQ[$];
  logic [7:0]  modeQ[$];

  srf_serial_ready u_dut (.sys_clk(sys_clk), .rstn(rstn), .sclk(sclk), .csN(csN), .din(din), .dout(dout),
    .doutEn(doutEn), .readyN(readyN), .mainResult(mainResult), .mainStrobe(mainStrobe),
    .mainUpdateSoon(mainUpdateSoon), .mainEnable(mainEnable), .auxResult(auxResult), .auxStrobe(auxStrobe),
    .auxUpdateSoon(auxUpdateSoon), .auxEnable(auxEnable), .calDone(calDone), .applyHold(applyHold),
    .lostClear(lostClear), .modeBits(modeBits), .modeWritten(modeWritten), .configReg(configReg),
    .calibReg(calibReg), .cmdFifoReady(cmdFifoReady), .writeLost(writeLost), .statusFlags(statusFlags));
  srf_host_model u_host (.sclk(sclk), .csN(csN), .din(din), .dout(dout), .doutEn(doutEn));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic close_out;
    if (error_cnt == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One-cycle pulse on {calDone, auxStrobe, auxUpdateSoon, mainStrobe, mainUpdateSoon}
  task automatic core(input logic [4:0] p);
    @(posedge sys_clk);
    #1 {calDone, auxStrobe, auxUpdateSoon, mainStrobe, mainUpdateSoon} = p;
    @(posedge sys_clk);
    #1 {calDone, auxStrobe, auxUpdateSoon, mainStrobe, mainUpdateSoon} = 5'h00;
  endtask : core

  // stay == 0 waits (bounded) for the level, otherwise it must hold after stay cycles
  task automatic rdy(input logic exp, input int stay);
    for (int i = 0; i < 40 && readyN !== exp && stay == 0; i++)
      @(posedge sys_clk);
    repeat (stay) @(posedge sys_clk);
    #2 chk("readyN", {23'h0, exp}, {23'h0, readyN});
  endtask : rdy

  task automatic rd(input logic [7:0] cmd, input logic [23:0] exp);
    readQ.push_back(exp);
    u_host.frame(cmd, 24'h000000, 1'b0, 1'b0);
  endtask : rd

  // Watchers take the oldest note whenever a result shows
  always @(u_host.gotWord) chk("read word", readQ.pop_front(), u_host.lastWord);
  always @(posedge sys_clk)
    if (modeWritten === 1'b1)
      chk("modeBits", {16'h0, modeQ.pop_front()}, {16'h0, modeBits});

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      error_cnt++;
      close_out();
    end
  end

  initial
  begin
    seed = 65;
    {rstn, mainStrobe, mainUpdateSoon, auxStrobe, auxUpdateSoon, calDone, applyHold, lostClear} = 8'h00;
    {mainEnable, auxEnable} = 2'b11;
    mainResult = 24'h000000;
    auxResult  = 16'h0000;
    repeat (12) @(posedge sys_clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 mainResult = 24'($random(seed));
    core(5'h02);
    rdy(1'b0, 0);
    rd(8'h80, 24'h000001);
    rd(8'h82, mainResult);
    rdy(1'b1, 0);
    @(posedge sys_clk);
    #1 auxEnable = 1'b0;
    auxResult = 16'($random(seed));
    core(5'h08);
    rdy(1'b1, 8);
    rd(8'h80, 24'h000002);
    rd(8'h83, {8'h00, auxResult});
    @(posedge sys_clk);
    #1 auxEnable = 1'b1;
    core(5'h08);
    rdy(1'b0, 0);
    core(5'h04);
    rdy(1'b1, 0);
    core(5'h02);
    rdy(1'b0, 0);
    core(5'h01);
    rdy(1'b1, 0);
    core(5'h03);
    rdy(1'b0, 0);
    rd(8'h82, mainResult);
    core(5'h10);
    rdy(1'b0, 0);
    rd(8'h82, mainResult);
    rdy(1'b0, 8);
    m = 8'($random(seed));
    modeQ.push_back(m);
    u_host.frame(8'h01, {16'h0, m}, 1'b0, 1'b0);
    rdy(1'b1, 0);
    for (int a = 4; a < 6; a++)
    begin
      v = 24'($random(seed));
      u_host.frame(8'(a), v, 1'b1, 1'b1);
      rd(8'(8'h80 | a), v);
    end
    chk("calibReg", v, calibReg);
    u_host.frame(8'h02, ~mainResult, 1'b0, 1'b0);
    rd(8'h82, mainResult);
    // Queue full: eight stalled writes fit, the ninth is dropped
    @(posedge sys_clk);
    #1 applyHold = 1'b1;
    for (int k = 0; k < 9; k++)
    begin
      m = 8'($random(seed));
      if (k < 8)
        modeQ.push_back(m);
      if (k == 7)
        v = {16'h0000, m};
      u_host.frame(8'h01, {16'h0, m}, 1'b0, 1'b0);
    end
    repeat (6) @(posedge sys_clk);
    #1 chk("cmdFifoReady", 24'h0, {23'h0, cmdFifoReady});
    chk("writeLost", 24'h1, {23'h0, writeLost});
    applyHold = 1'b0;
    repeat (20) @(posedge sys_clk);
    #1 lostClear = 1'b1;
    @(posedge sys_clk);
    #1 lostClear = 1'b0;
    rd(8'h81, v);
    chk("writeLost", 24'h0, {23'h0, writeLost});
    core(5'h02);
    @(posedge sys_clk);
    #1 rstn = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 chk("configReg", 24'h000000, configReg);
    chk("modeBits", 24'h000000, {16'h0, modeBits});
    chk("readyN", 24'h000001, {23'h0, readyN});
    rstn = 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(8'h80, 24'h000000);
    repeat (4) @(posedge sys_clk);
    close_out();
  end
endmodule : srf_serial_ready_tb
